/* File: common/phy_regs_pkg.sv */
// constants, field positions and carriers for the phy main page registers
// assumes a management master that issues one register access per request
// Behaviour
// - indices 0 to 15 answer the same on page zero, one or two
// - index 31 holds the page selection steering later accesses
// - control bit 15 write of one pulses soft reset, then self-clears
// - control bit 14 selects digital loopback, default zero
// - speed pair bits 6,13: 00 ten, 01 hundred, 10 gigabit, 11 reserved (decoded here as ten)
// - with auto-negotiation enabled, speed and duplex come from negotiation
// - control bit 11 enters general power down, clearing restores, default 0
// - control bit 9 write of one restarts negotiation, then self-clears
// - control bit 8 picks full or half duplex when negotiation is off
// - status 14:11 read one, status 15, 10, 9 read zero
// - status bit 8 reads one for extended status available
// - status bit 5 shows negotiation complete, zero at reset
// - status bit 4 shows remote fault while detected
// - status bit 3 reads constant one, negotiation ability
// - status bit 2 is latching-low link indicator, zero at reset
// - status bit 1 shows jabber while detected
// - status bit 0 reads constant one, extended capability
// - identifier one reads a fixed sixteen-bit value
// - index 20 holds a false carrier counter
// - index 21 holds a link disconnect counter
// - index 25 interrupt mask, 26 interrupt status, 27 reserved
// - pages one or two redirect indices 16 to 30; zero restores main
package phy_regs_pkg;
    localparam logic [4:0] IDX_CONTROL = 5'h00;
    localparam logic [4:0] IDX_STATUS = 5'h01;
    localparam logic [4:0] IDX_ID_UPPER = 5'h02;
    localparam logic [4:0] IDX_EXT_FIRST = 5'h10;
    localparam logic [4:0] IDX_FALSE_CARRIER = 5'h14;
    localparam logic [4:0] IDX_LINK_DISC = 5'h15;
    localparam logic [4:0] IDX_TENBASE_EXT = 5'h16;
    localparam logic [4:0] IDX_EXT_CTRL_ONE = 5'h17;
    localparam logic [4:0] IDX_EXT_CTRL_TWO = 5'h18;
    localparam logic [4:0] IDX_IRQ_MASK = 5'h19;
    localparam logic [4:0] IDX_IRQ_STATUS = 5'h1a;
    localparam logic [4:0] IDX_RSVD_27 = 5'h1b;
    localparam logic [4:0] IDX_AUX = 5'h1c;
    localparam logic [4:0] IDX_IND_MODE = 5'h1d;
    localparam logic [4:0] IDX_IND_BEHAVIOR = 5'h1e;
    localparam logic [4:0] IDX_EXT_LAST = 5'h1e;
    localparam logic [4:0] IDX_PAGE_SELECT = 5'h1f;
    localparam int CTL_RESET_BIT = 15;
    localparam int CTL_LOOPBACK_BIT = 14;
    localparam int CTL_SPEED_LO_BIT = 13;
    localparam int CTL_AN_EN_BIT = 12;
    localparam int CTL_PDOWN_BIT = 11;
    localparam int CTL_RESTART_BIT = 9;
    localparam int CTL_DUPLEX_BIT = 8;
    localparam int CTL_SPEED_HI_BIT = 6;
    localparam logic CTL_AN_EN_RST = 1'b1;
    localparam logic CTL_SPEED_HI_RST = 1'b1;
    localparam logic CTL_OTHER_RST = 1'b0;
    localparam logic [15:0] STATUS_FIXED = 16'h7909;
    localparam int ST_AN_DONE_BIT = 5;
    localparam int ST_RFAULT_BIT = 4;
    localparam int ST_LINK_BIT = 2;
    localparam int ST_JABBER_BIT = 1;
    localparam logic [15:0] PAGE_MAIN = 16'h0000;
    localparam logic [15:0] PAGE_EXT_ONE = 16'h0001;
    localparam logic [15:0] PAGE_EXT_TWO = 16'h0002;
    localparam logic [1:0] SPEED_10 = 2'b00;
    localparam logic [1:0] SPEED_100 = 2'b01;
    localparam logic [1:0] SPEED_1000 = 2'b10;
    localparam int IRQ_LINK_DOWN_BIT = 0;
    localparam int IRQ_AN_DONE_BIT = 1;
    localparam int IRQ_RFAULT_BIT = 2;
    localparam int IRQ_W = 3;

    typedef struct packed {
        logic valid;
        logic write;
        logic [4:0] index;
        logic [15:0] wdata;
    } mgmt_req_s;

    typedef struct packed {
        logic link_up;
        logic an_complete;
        logic remote_fault;
        logic jabber;
        logic [1:0] an_speed;
        logic an_full_duplex;
        logic false_carrier;
        logic link_lost;
    } line_state_s;
endpackage

/* File: rtl/phy_main_page_control_status.sv */
// main page management registers of the integrated ethernet phy
// assumes the mac management controller delivers one access per request
// and that line_state comes from logic on the same clock
`timescale 1ns/1ps
module phy_main_page_control_status #(
    parameter logic [15:0] ID_UPPER = 16'h1234, // value is arbitrary
    parameter int CNT_W = 16
)(
    input wire logic clk,
    input wire logic reset,
    input wire phy_regs_pkg::mgmt_req_s mgmt_req,
    output logic mgmt_ack,
    output logic [15:0] mgmt_rdata,
    input wire phy_regs_pkg::line_state_s line_state,
    output logic soft_reset,
    output logic an_restart,
    output logic loopback,
    output logic power_down,
    output logic an_enable,
    output logic [1:0] speed_mode,
    output logic full_duplex
);

    function automatic logic ext_hit(input logic [4:0] idx,
                                     input logic [15:0] pg);
        return (pg == phy_regs_pkg::PAGE_EXT_ONE ||
                pg == phy_regs_pkg::PAGE_EXT_TWO) &&
               idx >= phy_regs_pkg::IDX_EXT_FIRST &&
               idx <= phy_regs_pkg::IDX_EXT_LAST;
    endfunction

    function automatic logic plain_rw(input logic [4:0] idx);
        case (idx)
            phy_regs_pkg::IDX_TENBASE_EXT,
            phy_regs_pkg::IDX_EXT_CTRL_ONE,
            phy_regs_pkg::IDX_EXT_CTRL_TWO,
            phy_regs_pkg::IDX_IRQ_MASK,
            phy_regs_pkg::IDX_AUX,
            phy_regs_pkg::IDX_IND_MODE,
            phy_regs_pkg::IDX_IND_BEHAVIOR: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    // clear on read; an event in the read cycle is kept as the first count
    function automatic logic [CNT_W-1:0] next_count(
        input logic [CNT_W-1:0] cnt, input logic ev, input logic clr);
        logic [CNT_W-1:0] res;
        res = cnt;
        if (clr)
            res = {{(CNT_W-1){1'b0}}, ev};
        else if (ev && cnt != {CNT_W{1'b1}})
            res = cnt + {{(CNT_W-1){1'b0}}, 1'b1};
        return res;
    endfunction

    function automatic logic [1:0] manual_speed(input logic hi,
                                                input logic lo);
        case ({hi, lo})
            2'b01: return phy_regs_pkg::SPEED_100;
            2'b10: return phy_regs_pkg::SPEED_1000;
            default: return phy_regs_pkg::SPEED_10;
        endcase
    endfunction

    logic [15:0] page;
    logic on_ext;
    logic ext_pg;
    logic [3:0] ext_slot;
    logic wr_main;
    logic rd_main;
    logic wr_ext;
    logic ctrl_wr;
    logic status_rd;
    logic speed_lo;
    logic speed_hi;
    logic duplex;
    logic an_done;
    logic rfault;
    logic jabber;
    logic link_latched;
    logic link_prev;
    logic an_prev;
    logic rfault_prev;
    logic [CNT_W-1:0] fc_count;
    logic [CNT_W-1:0] ld_count;
    logic [phy_regs_pkg::IRQ_W-1:0] irq_status;
    logic [phy_regs_pkg::IRQ_W-1:0] irq_raise;
    logic [15:0] main_store [16:30];
    logic [15:0] ext_mem [2][15];
    logic [15:0] ctrl_word;
    logic [15:0] status_word;
    logic [15:0] next_rdata;

    // pages one and two only shadow 16..30; 0..15 and 31 stay main
    assign on_ext = ext_hit(mgmt_req.index, page);
    assign ext_pg = (page == phy_regs_pkg::PAGE_EXT_TWO);
    assign ext_slot = 4'(mgmt_req.index - phy_regs_pkg::IDX_EXT_FIRST);
    assign wr_main = mgmt_req.valid & mgmt_req.write & ~on_ext;
    assign rd_main = mgmt_req.valid & ~mgmt_req.write & ~on_ext;
    assign wr_ext = mgmt_req.valid & mgmt_req.write & on_ext;
    assign ctrl_wr = wr_main && mgmt_req.index == phy_regs_pkg::IDX_CONTROL;
    assign status_rd = rd_main &&
                       mgmt_req.index == phy_regs_pkg::IDX_STATUS;

    always_ff @(posedge clk)
    begin
        if (reset)
            page <= phy_regs_pkg::PAGE_MAIN;
        else if (wr_main && mgmt_req.index == phy_regs_pkg::IDX_PAGE_SELECT)
            page <= mgmt_req.wdata;
    end

    // control register fields; bits 10, 7 and 5:0 are not stored
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            loopback <= phy_regs_pkg::CTL_OTHER_RST;
            speed_lo <= phy_regs_pkg::CTL_OTHER_RST;
            an_enable <= phy_regs_pkg::CTL_AN_EN_RST;
            power_down <= phy_regs_pkg::CTL_OTHER_RST;
            duplex <= phy_regs_pkg::CTL_OTHER_RST;
            speed_hi <= phy_regs_pkg::CTL_SPEED_HI_RST;
        end
        else if (ctrl_wr)
        begin
            loopback <= mgmt_req.wdata[phy_regs_pkg::CTL_LOOPBACK_BIT];
            speed_lo <= mgmt_req.wdata[phy_regs_pkg::CTL_SPEED_LO_BIT];
            an_enable <= mgmt_req.wdata[phy_regs_pkg::CTL_AN_EN_BIT];
            power_down <= mgmt_req.wdata[phy_regs_pkg::CTL_PDOWN_BIT];
            duplex <= mgmt_req.wdata[phy_regs_pkg::CTL_DUPLEX_BIT];
            speed_hi <= mgmt_req.wdata[phy_regs_pkg::CTL_SPEED_HI_BIT];
        end
    end

    // self-clearing strobes: each reads back one for a single cycle
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            soft_reset <= 1'b0;
            an_restart <= 1'b0;
        end
        else
        begin
            soft_reset <= ctrl_wr &
                mgmt_req.wdata[phy_regs_pkg::CTL_RESET_BIT];
            an_restart <= ctrl_wr &
                mgmt_req.wdata[phy_regs_pkg::CTL_RESTART_BIT];
        end
    end

    // power down does not stop negotiation here; the master sequences it
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            speed_mode <= phy_regs_pkg::SPEED_10;
            full_duplex <= 1'b0;
        end
        else if (an_enable)
        begin
            speed_mode <= line_state.an_speed;
            full_duplex <= line_state.an_full_duplex;
        end
        else
        begin
            speed_mode <= manual_speed(speed_hi, speed_lo);
            full_duplex <= duplex;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            an_done <= 1'b0;
            rfault <= 1'b0;
            jabber <= 1'b0;
        end
        else
        begin
            an_done <= line_state.an_complete & an_enable;
            rfault <= line_state.remote_fault;
            jabber <= line_state.jabber;
        end
    end

    // latching low: any drop sticks until status is read
    always_ff @(posedge clk)
    begin
        if (reset)
            link_latched <= 1'b0;
        else if (status_rd)
            link_latched <= line_state.link_up;
        else
            link_latched <= link_latched & line_state.link_up;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            fc_count <= '0;
            ld_count <= '0;
        end
        else
        begin
            fc_count <= next_count(fc_count, line_state.false_carrier,
                rd_main &&
                mgmt_req.index == phy_regs_pkg::IDX_FALSE_CARRIER);
            ld_count <= next_count(ld_count, line_state.link_lost,
                rd_main &&
                mgmt_req.index == phy_regs_pkg::IDX_LINK_DISC);
        end
    end

    assign irq_raise[phy_regs_pkg::IRQ_LINK_DOWN_BIT] =
        link_prev & ~line_state.link_up;
    assign irq_raise[phy_regs_pkg::IRQ_AN_DONE_BIT] =
        ~an_prev & line_state.an_complete;
    assign irq_raise[phy_regs_pkg::IRQ_RFAULT_BIT] =
        ~rfault_prev & line_state.remote_fault;

    // sticky interrupt causes, cleared by reading; a new cause wins
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            link_prev <= 1'b0;
            an_prev <= 1'b0;
            rfault_prev <= 1'b0;
            irq_status <= '0;
        end
        else
        begin
            link_prev <= line_state.link_up;
            an_prev <= line_state.an_complete;
            rfault_prev <= line_state.remote_fault;
            if (rd_main && mgmt_req.index == phy_regs_pkg::IDX_IRQ_STATUS)
                irq_status <= irq_raise;
            else
                irq_status <= irq_status | irq_raise;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            for (int i = 16; i <= 30; i++)
                main_store[i] <= '0;
        end
        else if (wr_main && plain_rw(mgmt_req.index))
            main_store[mgmt_req.index] <= mgmt_req.wdata;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            for (int p = 0; p < 2; p++)
                for (int i = 0; i < 15; i++)
                    ext_mem[p][i] <= '0;
        end
        else if (wr_ext)
            ext_mem[ext_pg][ext_slot] <= mgmt_req.wdata;
    end

    always_comb
    begin
        ctrl_word = '0;
        ctrl_word[phy_regs_pkg::CTL_RESET_BIT] = soft_reset;
        ctrl_word[phy_regs_pkg::CTL_LOOPBACK_BIT] = loopback;
        ctrl_word[phy_regs_pkg::CTL_SPEED_LO_BIT] = speed_lo;
        ctrl_word[phy_regs_pkg::CTL_AN_EN_BIT] = an_enable;
        ctrl_word[phy_regs_pkg::CTL_PDOWN_BIT] = power_down;
        ctrl_word[phy_regs_pkg::CTL_RESTART_BIT] = an_restart;
        ctrl_word[phy_regs_pkg::CTL_DUPLEX_BIT] = duplex;
        ctrl_word[phy_regs_pkg::CTL_SPEED_HI_BIT] = speed_hi;
        status_word = phy_regs_pkg::STATUS_FIXED;
        status_word[phy_regs_pkg::ST_AN_DONE_BIT] = an_done;
        status_word[phy_regs_pkg::ST_RFAULT_BIT] = rfault;
        status_word[phy_regs_pkg::ST_LINK_BIT] = link_latched;
        status_word[phy_regs_pkg::ST_JABBER_BIT] = jabber;
    end

    always_comb
    begin
        next_rdata = '0;
        if (on_ext)
            next_rdata = ext_mem[ext_pg][ext_slot];
        else
        begin
            case (mgmt_req.index)
                phy_regs_pkg::IDX_CONTROL: next_rdata = ctrl_word;
                phy_regs_pkg::IDX_STATUS: next_rdata = status_word;
                phy_regs_pkg::IDX_ID_UPPER: next_rdata = ID_UPPER;
                phy_regs_pkg::IDX_FALSE_CARRIER: next_rdata = 16'(fc_count);
                phy_regs_pkg::IDX_LINK_DISC: next_rdata = 16'(ld_count);
                phy_regs_pkg::IDX_IRQ_STATUS: next_rdata = 16'(irq_status);
                phy_regs_pkg::IDX_PAGE_SELECT: next_rdata = page;
                default:
                begin
                    if (plain_rw(mgmt_req.index))
                        next_rdata = main_store[mgmt_req.index];
                end
            endcase
        end
    end

    // unsupported indices answer with zero rather than stalling the master
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            mgmt_ack <= 1'b0;
            mgmt_rdata <= '0;
        end
        else
        begin
            mgmt_ack <= mgmt_req.valid;
            if (mgmt_req.valid && !mgmt_req.write)
                mgmt_rdata <= next_rdata;
        end
    end

    AST_SOFT_RESET_SC: assert property (@(posedge clk) disable iff (reset)
        ctrl_wr && mgmt_req.wdata[phy_regs_pkg::CTL_RESET_BIT] &&
        !mgmt_req.wdata[phy_regs_pkg::CTL_RESTART_BIT]
        |=> soft_reset && !an_restart ##1 !soft_reset || $past(ctrl_wr))
        else $error("soft reset did not pulse for one cycle");

    AST_RESTART_SC: assert property (@(posedge clk) disable iff (reset)
        ctrl_wr && mgmt_req.wdata[phy_regs_pkg::CTL_RESTART_BIT]
        ##1 !ctrl_wr |-> an_restart ##1 !an_restart)
        else $error("restart strobe did not clear itself");

    AST_LOOPBACK: assert property (@(posedge clk) disable iff (reset)
        ctrl_wr ##1 !ctrl_wr [*2]
        |-> loopback == $past(mgmt_req.wdata[phy_regs_pkg::CTL_LOOPBACK_BIT],
                              2))
        else $error("loopback does not follow the written bit");

    AST_MANUAL_SPEED: assert property (@(posedge clk) disable iff (reset)
        !an_enable && speed_hi && !speed_lo |=> speed_mode == 2'b10)
        else $error("manual gigabit speed not applied");

    AST_AN_OVERRIDE: assert property (@(posedge clk) disable iff (reset)
        an_enable |=> speed_mode == $past(line_state.an_speed) &&
                      full_duplex == $past(line_state.an_full_duplex))
        else $error("negotiated speed or duplex not applied");

    AST_DUPLEX: assert property (@(posedge clk) disable iff (reset)
        !an_enable |=> full_duplex == $past(duplex))
        else $error("manual duplex not applied");

    AST_POWER_DOWN: assert property (@(posedge clk) disable iff (reset)
        ctrl_wr && mgmt_req.wdata[phy_regs_pkg::CTL_PDOWN_BIT]
        |=> power_down ##1 (power_down || $past(ctrl_wr)))
        else $error("power down not entered on write");

    AST_STATUS_CONST: assert property (@(posedge clk) disable iff (reset)
        status_rd |=> mgmt_rdata[15:8] == 8'h79 &&
                      mgmt_rdata[7:6] == 2'b00 &&
                      mgmt_rdata[3] && mgmt_rdata[0])
        else $error("fixed status bits wrong");

    AST_AN_DONE: assert property (@(posedge clk) disable iff (reset)
        status_rd |=> mgmt_rdata[phy_regs_pkg::ST_AN_DONE_BIT] ==
                      $past(an_done))
        else $error("negotiation complete bit wrong");

    AST_LINK_LATCH: assert property (@(posedge clk) disable iff (reset)
        !line_state.link_up ##1 !status_rd [*3] |-> !link_latched)
        else $error("link bit rose before being read");

    AST_LINK_READ: assert property (@(posedge clk) disable iff (reset)
        status_rd |=> link_latched == $past(line_state.link_up))
        else $error("link bit did not refresh on read");

    AST_ID_UPPER: assert property (@(posedge clk) disable iff (reset)
        rd_main && mgmt_req.index == phy_regs_pkg::IDX_ID_UPPER
        |=> mgmt_rdata == ID_UPPER)
        else $error("identifier one read wrong");

    AST_RSVD_27: assert property (@(posedge clk) disable iff (reset)
        rd_main && mgmt_req.index == phy_regs_pkg::IDX_RSVD_27
        |=> mgmt_rdata == 16'h0000)
        else $error("reserved index 27 not zero");

    AST_PAGE_ZERO: assert property (@(posedge clk) disable iff (reset)
        wr_main && mgmt_req.index == phy_regs_pkg::IDX_PAGE_SELECT &&
        mgmt_req.wdata == 16'h0000 |=> !on_ext)
        else $error("writing zero did not restore main page");

    COV_SOFT_RESET: cover property (@(posedge clk) disable iff (reset)
        ctrl_wr ##1 soft_reset);
    COV_EXT_PAGE: cover property (@(posedge clk) disable iff (reset)
        wr_ext && ext_pg);
    COV_LINK_RELATCH: cover property (@(posedge clk) disable iff (reset)
        !link_latched ##1 status_rd ##1 link_latched);
    COV_IRQ_READ: cover property (@(posedge clk) disable iff (reset)
        irq_status != '0 ##1 rd_main &&
        mgmt_req.index == phy_regs_pkg::IDX_IRQ_STATUS);

endmodule

/* File: verification/mgmt_master_model.sv */
// station management master model driving the phy register block
// assumes one access per request, answered one cycle after it is taken
`timescale 1ns/1ps
module mgmt_master_model (
    input wire logic clk,
    input wire logic mgmt_ack,
    input wire logic [15:0] mgmt_rdata,
    output phy_regs_pkg::mgmt_req_s mgmt_req
);
    logic ack_seen;
    initial mgmt_req = '0;
    initial ack_seen = 1'b0;
    // registers are reached only through this request path
    task automatic access(input logic wr, input logic [4:0] idx,
        input logic [15:0] wd, output logic [15:0] rd);
        @(posedge clk);
        #1 mgmt_req = {1'b1, wr, idx, wd};
        @(posedge clk);
        // released fields show the inverse, never the old value
        #1 mgmt_req = {1'b0, ~wr, ~idx, ~wd};
        ack_seen = mgmt_ack;
        rd = mgmt_rdata;
    endtask
    task automatic ctrl_write(input logic [15:0] wd);
        logic [15:0] rd;
        if (wd[11])
        begin
            access(1'b1, 5'h00, wd & 16'he7ff, rd);
            wd[12] = 1'b0;
        end
        access(1'b1, 5'h00, wd, rd);
    endtask
endmodule

/* File: verification/phy_main_page_control_status_test.sv */
// self-checking bench for the phy main page register block
// assumes the master model answers in the ack cycle of each access
`timescale 1ns/1ps
`define CHK(nm, e, g) \
    begin \
        check_count++; \
        if ((g) !== (e)) \
        begin \
            mismatches++; \
            $display("MISMATCH %s exp %h got %h", nm, e, g); \
        end \
    end
module phy_main_page_control_status_test;
    localparam logic [15:0] ID_VAL = 16'h5a3c; // value is arbitrary
    logic clk = 1'b0;
    logic reset = 1'b1;
    phy_regs_pkg::mgmt_req_s req;
    phy_regs_pkg::line_state_s ls = '0;
    logic ack, soft_reset, an_restart, loopback, power_down, an_enable;
    logic full_duplex;
    logic [1:0] speed_mode;
    logic [15:0] rdata;
    int mismatches = 0;
    int check_count = 0;
    int cycles = 0;
    phy_main_page_control_status #(.ID_UPPER(ID_VAL), .CNT_W(16))
        phy_main_page_control_status_i (.clk(clk), .reset(reset),
        .mgmt_req(req), .mgmt_ack(ack), .mgmt_rdata(rdata),
        .line_state(ls), .soft_reset(soft_reset), .an_restart(an_restart),
        .loopback(loopback), .power_down(power_down),
        .an_enable(an_enable), .speed_mode(speed_mode),
        .full_duplex(full_duplex));
    mgmt_master_model mgmt_master_model_i (.clk(clk), .mgmt_ack(ack),
        .mgmt_rdata(rdata), .mgmt_req(req));
    initial
    begin
        forever #4 clk = ~clk;
    end
    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            mismatches++;
            close_out();
        end
    end
    task automatic rd_chk(input string nm, input logic [4:0] i,
        input logic [15:0] e);
        logic [15:0] d;
        mgmt_master_model_i.access(1'b0, i, 16'h0000, d);
        `CHK("ack", 1'b1, mgmt_master_model_i.ack_seen)
        `CHK(nm, e, d)
    endtask
    task automatic wr(input logic [4:0] i, input logic [15:0] d);
        logic [15:0] x;
        mgmt_master_model_i.access(1'b1, i, d, x);
    endtask
    task automatic wait_cycles(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic t_reset;
        `CHK("an_enable", 1'b1, an_enable)
        `CHK("loopback", 1'b0, loopback)
        `CHK("power_down", 1'b0, power_down)
        rd_chk("ctrl", 5'h00, 16'h1040);
    endtask
    task automatic t_strobes;
        wr(5'h00, 16'h9040);
        `CHK("soft_reset", 1'b1, soft_reset)
        wait_cycles(1);
        `CHK("soft_reset end", 1'b0, soft_reset)
        rd_chk("ctrl sc", 5'h00, 16'h1040);
        wr(5'h00, 16'h1240);
        `CHK("an_restart", 1'b1, an_restart)
        wait_cycles(1);
        `CHK("an_restart end", 1'b0, an_restart)
        rd_chk("ctrl sc9", 5'h00, 16'h1040);
    endtask
    task automatic t_manual;
        logic [15:0] w;
        wr(5'h00, 16'h04bf);
        rd_chk("ctrl rsvd", 5'h00, 16'h0000);
        ls.an_speed = 2'b10;
        for (int s = 0; s < 4; s++)
        begin
            w = {2'b01, s[0], 4'h0, s[0], 1'b0, s[1], 6'h00};
            wr(5'h00, w);
            wait_cycles(1);
            `CHK("speed", (s == 3) ? 2'b00 : s[1:0], speed_mode)
            `CHK("duplex", s[0], full_duplex)
            `CHK("loopback", 1'b1, loopback)
        end
        ls.an_speed = 2'b01;
        ls.an_full_duplex = 1'b1;
        wr(5'h00, 16'h1000);
        wait_cycles(2);
        `CHK("an speed", 2'b01, speed_mode)
        `CHK("an duplex", 1'b1, full_duplex)
        `CHK("loopback off", 1'b0, loopback)
    endtask
    task automatic t_pdown;
        mgmt_master_model_i.ctrl_write(16'h1800);
        `CHK("pdown", 1'b1, power_down)
        `CHK("an off", 1'b0, an_enable)
        wr(5'h00, 16'h1000);
        `CHK("pdown clr", 1'b0, power_down)
    endtask
    task automatic t_status;
        rd_chk("status", 5'h01, 16'h7909);
        ls.an_complete = 1'b1;
        ls.remote_fault = 1'b1;
        ls.jabber = 1'b1;
        wait_cycles(2);
        rd_chk("status ev", 5'h01, 16'h793b);
        rd_chk("irq", 5'h1a, 16'h0006);
        rd_chk("irq clr", 5'h1a, 16'h0000);
        ls.an_complete = 1'b0;
        ls.remote_fault = 1'b0;
        ls.jabber = 1'b0;
        wr(5'h1b, 16'hffff);
        rd_chk("rsvd27", 5'h1b, 16'h0000);
    endtask
    task automatic t_link;
        ls.link_up = 1'b1;
        wait_cycles(2);
        rd_chk("link pre", 5'h01, 16'h7909);
        rd_chk("link up", 5'h01, 16'h790d);
        ls.link_up = 1'b0;
        wait_cycles(1);
        ls.link_up = 1'b1;
        rd_chk("link lost", 5'h01, 16'h7909);
        rd_chk("link back", 5'h01, 16'h790d);
        rd_chk("irq link", 5'h1a, 16'h0001);
    endtask
    task automatic t_counters;
        for (int k = 0; k < 5; k++)
        begin
            ls.false_carrier = (k < 3);
            ls.link_lost = (k < 2);
            wait_cycles(1);
        end
        ls.false_carrier = 1'b0;
        ls.link_lost = 1'b0;
        rd_chk("fc", 5'h14, 16'h0003);
        rd_chk("fc clr", 5'h14, 16'h0000);
        rd_chk("ld", 5'h15, 16'h0002);
    endtask
    task automatic t_pages;
        wr(5'h19, 16'h00a5);
        wr(5'h1f, 16'h0001);
        wr(5'h19, 16'h5a00);
        rd_chk("id p1", 5'h02, ID_VAL);
        rd_chk("ctrl p1", 5'h00, 16'h1000);
        rd_chk("page", 5'h1f, 16'h0001);
        wr(5'h1f, 16'h0002);
        rd_chk("p2 mask", 5'h19, 16'h0000);
        wr(5'h1f, 16'h0001);
        rd_chk("p1 mask", 5'h19, 16'h5a00);
        wr(5'h1f, 16'h0000);
        rd_chk("p0 mask", 5'h19, 16'h00a5);
    endtask
    initial
    begin
        repeat (10) @(posedge clk);
        #1 reset = 1'b0;
        t_reset();
        t_strobes();
        t_manual();
        t_pdown();
        t_status();
        t_link();
        t_counters();
        t_pages();
        close_out();
    end
endmodule
